// [dv/nvm_map_sva.sv]
// Concurrent checks on the ports of the flash map front end
module nvm_map_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Status and configuration load
  input wire logic command_complete_flag,
  input wire logic init_phase,
  input wire logic cfg_load_valid,
  input wire logic cfg_load_dbl_fault,
  input wire logic [7:0] cfg_lockdown_byte,
  input wire logic backdoor_unlock,
  // Decode
  input wire logic [17:0] gaddr,
  input wire logic [5:0] region,
  input wire logic [2:0] prog_zone,
  // Derived state
  input wire logic backdoor_allowed,
  input wire logic part_unlocked,
  input wire logic [15:0] command_object,
  input wire logic [7:0] controller_config,
  input wire logic [7:0] fault_interrupt_enable
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // ****************
  // Sequences
  // ****************
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_busy_wr;
    psel && penable && !pready && pwrite && !command_complete_flag && !init_phase;
  endsequence
  sequence s_rsvd_rd;
    psel && penable && !pready && !pwrite &&
      (paddr[7] || paddr[6:2] inside {5'h03, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h11, 5'h12, 5'h13});
  endsequence
  sequence s_good_load;
    cfg_load_valid && !cfg_load_dbl_fault;
  endsequence

  // ****************
  // Properties
  // ****************
  // Busy writes land nowhere, so the copies stay put one cycle after the write edge
  property p_busy_hold;
    s_busy_wr |=> ##1 ($stable(command_object) && $stable(controller_config) &&
      $stable(fault_interrupt_enable));
  endproperty

  AST_ONE_WAIT: assert property (s_access |=> pready)
    else $error("no answer one cycle after access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready stayed high");
  AST_BUSY_HOLD: assert property (p_busy_hold)
    else $error("register changed by write while busy");
  AST_RSVD_ZERO: assert property (s_rsvd_rd |=> prdata == 32'h0)
    else $error("reserved read not zero");
  AST_DBL_FAULT: assert property (cfg_load_valid && cfg_load_dbl_fault |=> ##1
    (!backdoor_allowed && !part_unlocked))
    else $error("faulty load left part open");
  AST_KEY_CODE: assert property (s_good_load |=> ##1
    (backdoor_allowed == (cfg_lockdown_byte[7:6] == nvm_map_pkg::CODE_OPEN)))
    else $error("backdoor enable wrong for code");
  AST_SEC_CODE: assert property (s_good_load ##1 !backdoor_unlock |->
    ##1 (part_unlocked == (cfg_lockdown_byte[1:0] == nvm_map_pkg::CODE_OPEN)))
    else $error("lock state wrong for code");
  AST_UNLOCK_FORCE: assert property (backdoor_unlock && backdoor_allowed |=> ##1
    part_unlocked)
    else $error("backdoor unlock did not open part");
  AST_PROG_REGION: assert property (gaddr[17:16] == 2'b11 |=> region ==
    nvm_map_pkg::RGN_PROG)
    else $error("program range not decoded");
  AST_LOWER_ZONE: assert property (gaddr[17:14] == 4'he |=> prog_zone == 3'h2)
    else $error("lower zone not flagged");
endmodule // nvm_map_sva

bind nvm_map_front nvm_map_sva chk_u (.mclk(mclk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .command_complete_flag(command_complete_flag), .init_phase(init_phase),
  .cfg_load_valid(cfg_load_valid), .cfg_load_dbl_fault(cfg_load_dbl_fault),
  .cfg_lockdown_byte(cfg_lockdown_byte), .backdoor_unlock(backdoor_unlock), .gaddr(gaddr),
  .region(region), .prog_zone(prog_zone), .backdoor_allowed(backdoor_allowed),
  .part_unlocked(part_unlocked), .command_object(command_object),
  .controller_config(controller_config), .fault_interrupt_enable(fault_interrupt_enable));

// [dv/tb.sv]
// Self-checking bench for the flash map front end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic dec; logic [17:0] a; logic rws; logic [7:0] w; logic [15:0] e;} row_s;
  logic mclk, reset, psel, penable, pwrite, ccf, special_mode, init_phase, pready;
  logic load_v, load_f, unlock, rws, allowed, unlocked;
  logic [7:0] paddr, lock_b, guard_b, cidx, cfgc, fen, pgc, dgc;
  logic [15:0] cobj;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [17:0] gaddr;
  logic [5:0] region;
  logic [2:0] prog_zone, cfg_zone;
  logic [1:0] ifr_zone;
  logic tick, slverr;
  int n_fail, checked, cyc, n;
  row_s rows [32];

  nvm_map_front dut_u (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(slverr), .command_complete_flag(ccf), .special_mode(special_mode),
    .init_phase(init_phase), .state_in(8'h80), .fault_in(8'h03), .cfg_load_valid(load_v),
    .cfg_load_dbl_fault(load_f), .cfg_lockdown_byte(lock_b), .cfg_prog_guard_byte(guard_b),
    .cfg_data_guard_byte(guard_b), .cfg_option_byte(lock_b), .backdoor_unlock(unlock),
    .gaddr(gaddr), .resource_window_select(rws), .region(region), .prog_zone(prog_zone),
    .cfg_zone(cfg_zone), .ifr_zone(ifr_zone), .tick_1mhz(tick), .backdoor_allowed(allowed),
    .part_unlocked(unlocked), .command_object_index_reg(cidx), .command_object(cobj),
    .controller_config(cfgc), .fault_interrupt_enable(fen), .program_array_guard_reg(pgc),
    .data_array_guard(dgc));

  // ****************
  // Clock and timeout
  // ****************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      conclude();
    end
  end

  // ****************
  // Tasks
  // ****************
  task conclude();
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  // One transfer; waits for pready with no assumed latency, then idles one cycle
  task apb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] rd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] x;
    apb(1'b0, a, 8'h00, x);
    chk(x, {24'h0, e});
  endtask
  // Byte is held after the pulse so the level checks see a steady source
  task load(input logic [7:0] b, input logic f);
    lock_b <= b;
    guard_b <= ~b;
    load_f <= f;
    load_v <= 1'b1;
    @(posedge mclk);
    load_v <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    {reset, ccf, pstrb} = {1'b1, 1'b1, 4'hf};
    {psel, penable, pwrite, paddr, pwdata, special_mode, init_phase} = '0;
    {load_v, load_f, unlock, rws, lock_b, guard_b, gaddr} = '0;
    // Decode rows pack region, program zone, configuration zone and row zone
    rows = '{'{0, 18'h08, 0, 8'hff, 16'h07}, '{0, 18'h0c, 0, 8'hff, 16'h00},
      '{0, 18'h10, 0, 8'hff, 16'h93}, '{0, 18'h14, 0, 8'hff, 16'h03},
      '{0, 18'h20, 0, 8'h5a, 16'h5a}, '{0, 18'h24, 0, 8'hff, 16'h8f},
      '{0, 18'h28, 0, 8'h12, 16'h12}, '{0, 18'h2c, 0, 8'h34, 16'h34},
      '{0, 18'h30, 0, 8'hff, 16'h00}, '{0, 18'h3c, 0, 8'hff, 16'h00},
      '{0, 18'h40, 0, 8'ha5, 16'ha5}, '{0, 18'h4c, 0, 8'hff, 16'h00},
      '{0, 18'h50, 0, 8'hff, 16'h00}, '{0, 18'h04, 0, 8'h00, 16'hff},
      '{0, 18'h18, 0, 8'hff, 16'h80}, '{0, 18'h1c, 0, 8'hff, 16'h03},
      '{1, 18'h00010, 0, 0, 16'h0200}, '{1, 18'h00500, 0, 0, 16'h0400},
      '{1, 18'h040b6, 1, 0, 16'h0801}, '{1, 18'h040c0, 1, 0, 16'h0802},
      '{1, 18'h05000, 1, 0, 16'h2000}, '{1, 18'h04000, 0, 0, 16'h0100},
      '{1, 18'h20000, 0, 0, 16'h0100}, '{1, 18'h30000, 0, 0, 16'h1020},
      '{1, 18'h38000, 0, 0, 16'h1040}, '{1, 18'h3ff00, 0, 0, 16'h1084},
      '{1, 18'h3ff08, 0, 0, 16'h1088}, '{1, 18'h3ff0c, 0, 0, 16'h108c},
      '{1, 18'h3ff0d, 0, 0, 16'h1090}, '{1, 18'h3ff0e, 0, 0, 16'h1094},
      '{1, 18'h3ff0f, 0, 0, 16'h1098}, '{1, 18'h3ffff, 0, 0, 16'h1080}};
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rdc(8'h00, 8'h00);
    rdc(8'h04, 8'hff);
    rdc(8'h20, 8'hff);
    foreach (rows[i]) begin
      if (rows[i].dec) begin
        gaddr <= rows[i].a;
        rws <= rows[i].rws;
        repeat (2) @(posedge mclk);
        chk({18'h0, region, prog_zone, cfg_zone, ifr_zone}, {16'h0, rows[i].e});
      end else begin
        wr(rows[i].a[7:0], rows[i].w);
        rdc(rows[i].a[7:0], rows[i].e[7:0]);
      end
    end
    chk({cidx, cobj, cfgc}, 32'h07123493);
    chk({fen, pgc, dgc, 7'h00, slverr}, 32'h035a8f00);
    wr(8'h00, 8'h13);
    rdc(8'h00, 8'h93);
    while (tick !== 1'b1) @(posedge mclk);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (tick !== 1'b1);
    chk(n, nvm_map_pkg::MCLK_HZ / nvm_map_pkg::TIMEBASE_HZ);
    wr(8'h00, 8'h45);
    wr(8'h00, 8'h0a);
    rdc(8'h00, 8'hc5);
    special_mode <= 1'b1;
    wr(8'h00, 8'h03);
    rdc(8'h00, 8'h83);
    special_mode <= 1'b0;
    wr(8'h00, 8'h45);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rdc(8'h00, 8'h00);
    ccf <= 1'b0;
    wr(8'h2c, 8'h77);
    rdc(8'h2c, 8'h00);
    init_phase <= 1'b1;
    wr(8'h2c, 8'h77);
    rdc(8'h2c, 8'h77);
    {init_phase, ccf, pstrb} <= {1'b0, 1'b1, 4'h0};
    wr(8'h2c, 8'h11);
    pstrb <= 4'hf;
    wr(8'hac, 8'h11);
    rdc(8'h2c, 8'h77);
    for (int k = 0; k < 4; k++) begin
      logic [7:0] b;
      b = {k[1:0], 4'hf, k[1:0]};
      load(b, 1'b0);
      chk({31'h0, allowed}, {31'h0, k == 2});
      chk({31'h0, unlocked}, {31'h0, k == 2});
      rdc(8'h04, b);
      rdc(8'h20, ~b);
      rdc(8'h24, ~b & nvm_map_pkg::DATA_GUARD_MASK);
      rdc(8'h40, b);
    end
    // Unlock pulse with the backdoor closed, then open
    for (int k = 0; k < 2; k++) begin
      load(k ? 8'hbd : 8'h7d, 1'b0);
      unlock <= 1'b1;
      @(posedge mclk);
      unlock <= 1'b0;
      repeat (3) @(posedge mclk);
      chk({31'h0, unlocked}, k);
    end
    rdc(8'h04, 8'hbe);
    load(8'hbe, 1'b1);
    rdc(8'h04, 8'hff);
    chk({30'h0, allowed, unlocked}, 32'h0);
    conclude();
  end
endmodule // tb

// [rtl/nvm_map_front.sv]
// Register file, address decoder, divider timebase and lockdown load for the flash controller
module nvm_map_front (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Controller status from the command engine
  input wire logic command_complete_flag,
  input wire logic special_mode,
  input wire logic init_phase,
  input wire logic [7:0] state_in,
  input wire logic [7:0] fault_in,
  // Reset sequence load of the configuration bytes
  input wire logic cfg_load_valid,
  input wire logic cfg_load_dbl_fault,
  input wire logic [7:0] cfg_lockdown_byte,
  input wire logic [7:0] cfg_prog_guard_byte,
  input wire logic [7:0] cfg_data_guard_byte,
  input wire logic [7:0] cfg_option_byte,
  input wire logic backdoor_unlock,
  // Global address decode
  input wire logic [17:0] gaddr,
  input wire logic resource_window_select,
  output logic [5:0] region,
  output logic [2:0] prog_zone,
  output logic [2:0] cfg_zone,
  output logic [1:0] ifr_zone,
  // Timebase and derived control
  output logic tick_1mhz,
  output logic backdoor_allowed,
  output logic part_unlocked,
  output logic [7:0] command_object_index_reg,
  output logic [15:0] command_object,
  output logic [7:0] controller_config,
  output logic [7:0] fault_interrupt_enable,
  output logic [7:0] program_array_guard_reg,
  output logic [7:0] data_array_guard
);

  // ****************************************************************
  // Bus access
  // ****************************************************************
  // Decode works on the word index; lanes above zero are ignored
  logic [4:0] idx;
  logic access;
  logic wr;
  logic write_open;
  logic [7:0] wbyte;
  logic [7:0] rd_d;
  logic [7:0] clock_divider_reg_q;
  logic [7:0] lockdown_state_reg_q;
  logic [7:0] nonvolatile_option_reg_q;
  logic [7:0] index_q;
  logic [7:0] cob_hi_q;
  logic [7:0] cob_lo_q;
  logic [7:0] config_q;
  logic [7:0] fault_en_q;
  logic [7:0] prog_guard_q;
  logic [7:0] data_guard_q;
  logic pready_q;

  assign idx = paddr[6:2];
  // First access cycle only, so the answer cycle cannot write twice
  assign access = psel && penable && !pready_q;
  assign write_open = command_complete_flag || init_phase;
  // Lane zero only carries the byte; strobe lane zero must be set
  assign wr = access && pwrite && pstrb[0] && write_open && (paddr[7] == 1'b0);
  assign wbyte = pwdata[7:0];

  // One wait state: answer on the second access cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= access;
    end
  end

  // ****************************************************************
  // Clock divider register
  // ****************************************************************
  logic div_write;
  assign div_write = wr && (idx == nvm_map_pkg::IDX_CLOCK_DIVIDER);

  always_ff @(posedge mclk) begin
    if (reset) begin
      clock_divider_reg_q <= nvm_map_pkg::RESET_BYTE;
    end else if (div_write) begin
      // Loaded flag records any accepted write, even one the lock refuses
      clock_divider_reg_q[nvm_map_pkg::DIV_LOADED_BIT] <= 1'b1;
      // Special mode may clear the lock; bit seven never follows the bus
      if (special_mode) begin
        clock_divider_reg_q[6:0] <= wbyte[6:0];
      end else if (!clock_divider_reg_q[nvm_map_pkg::DIV_LOCK_BIT]) begin
        clock_divider_reg_q[5:0] <= wbyte[5:0];
        clock_divider_reg_q[nvm_map_pkg::DIV_LOCK_BIT] <= wbyte[nvm_map_pkg::DIV_LOCK_BIT];
      end
    end
  end

  // ****************************************************************
  // 1 MHz timebase
  // ****************************************************************
  // Divide by value plus one; a stale value only stretches one period
  // Comparing with >= lets a smaller new value take hold at once
  logic [5:0] tb_cnt_q;
  logic tick_q;
  always_ff @(posedge mclk) begin
    if (reset) begin
      tb_cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else if (tb_cnt_q >= clock_divider_reg_q[5:0]) begin
      tb_cnt_q <= 6'h00;
      tick_q <= 1'b1;
    end else begin
      tb_cnt_q <= tb_cnt_q + 6'h01;
      tick_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Lockdown state register and configuration load
  // ****************************************************************
  // No bus write reaches this register
  // A load wins over an unlock pulse in the same cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      lockdown_state_reg_q <= nvm_map_pkg::LOCKDOWN_ALL_SET;
    end else if (cfg_load_valid) begin
      if (cfg_load_dbl_fault) begin
        lockdown_state_reg_q <= nvm_map_pkg::LOCKDOWN_ALL_SET;
      end else begin
        lockdown_state_reg_q <= cfg_lockdown_byte;
      end
    end else if (backdoor_unlock && backdoor_allowed) begin
      lockdown_state_reg_q[1:0] <= nvm_map_pkg::CODE_OPEN;
    end
  end

  // Unlock uses the registered enable, so it lags a load by two cycles
  always_ff @(posedge mclk) begin
    if (reset) begin
      backdoor_allowed <= 1'b0;
      part_unlocked <= 1'b0;
    end else begin
      backdoor_allowed <= (lockdown_state_reg_q[7:6] == nvm_map_pkg::CODE_OPEN);
      part_unlocked <= (lockdown_state_reg_q[1:0] == nvm_map_pkg::CODE_OPEN);
    end
  end

  // ****************************************************************
  // Plain control registers
  // ****************************************************************
  // Masks keep unimplemented bits at zero on read back
  always_ff @(posedge mclk) begin
    if (reset) begin
      index_q <= nvm_map_pkg::RESET_BYTE;
      cob_hi_q <= nvm_map_pkg::RESET_BYTE;
      cob_lo_q <= nvm_map_pkg::RESET_BYTE;
      config_q <= nvm_map_pkg::RESET_BYTE;
      fault_en_q <= nvm_map_pkg::RESET_BYTE;
    end else if (wr) begin
      case (idx)
        nvm_map_pkg::IDX_COMMAND_OBJECT_INDEX: index_q <= wbyte & nvm_map_pkg::INDEX_MASK;
        nvm_map_pkg::IDX_COMMAND_OBJECT_HIGH: cob_hi_q <= wbyte;
        nvm_map_pkg::IDX_COMMAND_OBJECT_LOW: cob_lo_q <= wbyte;
        nvm_map_pkg::IDX_CONTROLLER_CONFIG: config_q <= wbyte & nvm_map_pkg::CONFIG_MASK;
        nvm_map_pkg::IDX_FAULT_INTERRUPT_ENABLE: begin
          fault_en_q <= wbyte & nvm_map_pkg::FAULT_EN_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // Guards and option take their image from the configuration field
  // Bus writes to them share the busy and lane gating of the rest
  always_ff @(posedge mclk) begin
    if (reset) begin
      prog_guard_q <= nvm_map_pkg::RESET_GUARD;
      data_guard_q <= nvm_map_pkg::RESET_GUARD;
      nonvolatile_option_reg_q <= nvm_map_pkg::RESET_GUARD;
    end else if (cfg_load_valid && !cfg_load_dbl_fault) begin
      prog_guard_q <= cfg_prog_guard_byte;
      data_guard_q <= cfg_data_guard_byte & nvm_map_pkg::DATA_GUARD_MASK;
      nonvolatile_option_reg_q <= cfg_option_byte;
    end else if (wr && idx == nvm_map_pkg::IDX_PROGRAM_ARRAY_GUARD) begin
      prog_guard_q <= wbyte;
    end else if (wr && idx == nvm_map_pkg::IDX_DATA_ARRAY_GUARD) begin
      data_guard_q <= wbyte & nvm_map_pkg::DATA_GUARD_MASK;
    end else if (wr && idx == nvm_map_pkg::IDX_NONVOLATILE_OPTION) begin
      nonvolatile_option_reg_q <= wbyte;
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Unmapped and reserved indices read zero rather than undefined data
  always_comb begin
    rd_d = 8'h00;
    if (paddr[7] == 1'b0) begin
      case (idx)
        nvm_map_pkg::IDX_CLOCK_DIVIDER: rd_d = clock_divider_reg_q;
        nvm_map_pkg::IDX_LOCKDOWN_STATE: rd_d = lockdown_state_reg_q;
        nvm_map_pkg::IDX_COMMAND_OBJECT_INDEX: rd_d = index_q;
        nvm_map_pkg::IDX_CONTROLLER_CONFIG: rd_d = config_q;
        nvm_map_pkg::IDX_FAULT_INTERRUPT_ENABLE: rd_d = fault_en_q;
        nvm_map_pkg::IDX_CONTROLLER_STATE: rd_d = state_in;
        nvm_map_pkg::IDX_FAULT_FLAGS: rd_d = fault_in;
        nvm_map_pkg::IDX_PROGRAM_ARRAY_GUARD: rd_d = prog_guard_q;
        nvm_map_pkg::IDX_DATA_ARRAY_GUARD: rd_d = data_guard_q;
        nvm_map_pkg::IDX_COMMAND_OBJECT_HIGH: rd_d = cob_hi_q;
        nvm_map_pkg::IDX_COMMAND_OBJECT_LOW: rd_d = cob_lo_q;
        nvm_map_pkg::IDX_NONVOLATILE_OPTION: rd_d = nonvolatile_option_reg_q;
        default: rd_d = 8'h00;
      endcase
    end
  end

  // Read data is latched in the access cycle and stands until the next read
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (access && !pwrite) begin
      prdata <= {24'h000000, rd_d};
    end
  end

  // ****************************************************************
  // Global address decoder
  // ****************************************************************
  // Regions are registered, so each answer trails the address by one cycle
  logic [5:0] region_d;
  logic [2:0] prog_zone_d;
  logic [2:0] cfg_zone_d;
  logic [1:0] ifr_zone_d;
  always_comb begin
    region_d = nvm_map_pkg::RGN_NONE;
    if (gaddr <= nvm_map_pkg::REG_SPACE_END) begin
      region_d = nvm_map_pkg::RGN_REGS;
    end else if (gaddr >= nvm_map_pkg::DATA_FLASH_BASE && gaddr <= nvm_map_pkg::DATA_FLASH_END) begin
      region_d = nvm_map_pkg::RGN_DATA;
    end else if (gaddr >= nvm_map_pkg::RESOURCE_BASE && gaddr <= nvm_map_pkg::RESOURCE_END &&
                 resource_window_select) begin
      // Resource window decodes only while the select bit is set
      region_d = (gaddr <= nvm_map_pkg::PROG_IFR_END) ? nvm_map_pkg::RGN_IFR : nvm_map_pkg::RGN_RSVD;
    end else if (gaddr >= nvm_map_pkg::PROG_FLASH_BASE) begin
      region_d = nvm_map_pkg::RGN_PROG;
    end
  end

  // Zone 0 outside program flash, 1 middle, 2 lower, 4 higher; PROG_LOWER_BASE and address bit 14 set the exact limits
  always_comb begin
    prog_zone_d = 3'h0;
    if (region_d == nvm_map_pkg::RGN_PROG) begin
      if (gaddr >= nvm_map_pkg::PROG_LOWER_BASE && !gaddr[14]) begin
        prog_zone_d = 3'h2;
      end else if (gaddr >= nvm_map_pkg::PROG_LOWER_BASE) begin
        prog_zone_d = 3'h4;
      end else begin
        prog_zone_d = 3'h1;
      end
    end
  end

  always_comb begin
    // Key and configuration bytes decode on the address alone
    cfg_zone_d = 3'h0;
    if (gaddr >= nvm_map_pkg::BACKDOOR_KEY_BASE && gaddr <= nvm_map_pkg::BACKDOOR_KEY_END) begin
      cfg_zone_d = 3'h1;
    end else if (gaddr >= nvm_map_pkg::CFG_RESERVED_BASE && gaddr < nvm_map_pkg::CFG_PROG_GUARD) begin
      cfg_zone_d = 3'h2;
    end else if (gaddr == nvm_map_pkg::CFG_PROG_GUARD) begin
      cfg_zone_d = 3'h3;
    end else if (gaddr == nvm_map_pkg::CFG_DATA_GUARD) begin
      cfg_zone_d = 3'h4;
    end else if (gaddr == nvm_map_pkg::CFG_OPTION) begin
      cfg_zone_d = 3'h5;
    end else if (gaddr == nvm_map_pkg::CFG_LOCKDOWN) begin
      cfg_zone_d = 3'h6;
    end
  end

  always_comb begin
    ifr_zone_d = 2'h0;
    if (region_d == nvm_map_pkg::RGN_IFR) begin
      if (gaddr >= nvm_map_pkg::VERSION_ID_BASE && gaddr <= nvm_map_pkg::VERSION_ID_END) begin
        ifr_zone_d = 2'h1;
      end else if (gaddr >= nvm_map_pkg::PROGRAM_ONCE_BASE) begin
        ifr_zone_d = 2'h2;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      region <= nvm_map_pkg::RGN_NONE;
      prog_zone <= 3'h0;
      cfg_zone <= 3'h0;
      ifr_zone <= 2'h0;
    end else begin
      region <= region_d;
      prog_zone <= prog_zone_d;
      cfg_zone <= cfg_zone_d;
      ifr_zone <= ifr_zone_d;
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  // Copies trail their registers by one cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      tick_1mhz <= 1'b0;
      command_object_index_reg <= nvm_map_pkg::RESET_BYTE;
      command_object <= 16'h0000;
      controller_config <= nvm_map_pkg::RESET_BYTE;
      fault_interrupt_enable <= nvm_map_pkg::RESET_BYTE;
      program_array_guard_reg <= nvm_map_pkg::RESET_GUARD;
      data_array_guard <= nvm_map_pkg::RESET_GUARD;
    end else begin
      tick_1mhz <= tick_q;
      command_object_index_reg <= index_q;
      command_object <= {cob_hi_q, cob_lo_q};
      controller_config <= config_q;
      fault_interrupt_enable <= fault_en_q;
      program_array_guard_reg <= prog_guard_q;
      data_array_guard <= data_guard_q;
    end
  end

  assign pready = pready_q;
  // Refused writes are dropped silently, so no error is ever flagged
  assign pslverr = 1'b0;

endmodule // nvm_map_front

// [rtl/nvm_map_pkg.sv]
// Package of offsets, fields, reset values and timing for the flash map front end
package nvm_map_pkg;

  // ****************************************************************
  // Register offsets (byte-wide registers, one aligned APB word each)
  // ****************************************************************
  localparam logic [4:0] IDX_CLOCK_DIVIDER = 5'h00;
  localparam logic [4:0] IDX_LOCKDOWN_STATE = 5'h01;
  localparam logic [4:0] IDX_COMMAND_OBJECT_INDEX = 5'h02;
  localparam logic [4:0] IDX_RESERVED_ZERO = 5'h03;
  localparam logic [4:0] IDX_CONTROLLER_CONFIG = 5'h04;
  localparam logic [4:0] IDX_FAULT_INTERRUPT_ENABLE = 5'h05;
  localparam logic [4:0] IDX_CONTROLLER_STATE = 5'h06;
  localparam logic [4:0] IDX_FAULT_FLAGS = 5'h07;
  localparam logic [4:0] IDX_PROGRAM_ARRAY_GUARD = 5'h08;
  localparam logic [4:0] IDX_DATA_ARRAY_GUARD = 5'h09;
  localparam logic [4:0] IDX_COMMAND_OBJECT_HIGH = 5'h0a;
  localparam logic [4:0] IDX_COMMAND_OBJECT_LOW = 5'h0b;
  localparam logic [4:0] IDX_NONVOLATILE_OPTION = 5'h10;
  localparam logic [4:0] REG_COUNT = 5'h14;

  // ****************************************************************
  // Field positions and write masks
  // ****************************************************************
  localparam int DIV_LOADED_BIT = 7;
  localparam int DIV_LOCK_BIT = 6;
  localparam logic [7:0] DIV_VALUE_MASK = 8'h3f;
  localparam logic [7:0] INDEX_MASK = 8'h07;
  localparam logic [7:0] CONFIG_MASK = 8'h93;
  localparam logic [7:0] FAULT_EN_MASK = 8'h03;
  localparam logic [7:0] DATA_GUARD_MASK = 8'h8f;
  localparam logic [1:0] CODE_OPEN = 2'h2;
  localparam logic [7:0] LOCKDOWN_ALL_SET = 8'hff;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_GUARD = 8'hff;

  // ****************************************************************
  // Global address map (18-bit byte addresses)
  // ****************************************************************
  localparam logic [17:0] REG_SPACE_BASE = 18'h00000;
  localparam logic [17:0] REG_SPACE_END = 18'h003ff;
  localparam logic [17:0] DATA_FLASH_BASE = 18'h00400;
  localparam logic [17:0] DATA_FLASH_END = 18'h013ff;
  localparam logic [17:0] RESOURCE_BASE = 18'h04000;
  localparam logic [17:0] RESOURCE_END = 18'h07fff;
  localparam logic [17:0] PROG_FLASH_BASE = 18'h30000;
  localparam logic [17:0] PROG_FLASH_END = 18'h3ffff;
  localparam logic [17:0] PROG_LOWER_BASE = 18'h38000;
  localparam logic [17:0] PROG_HIGHER_TOP = 18'h3ffff;
  localparam logic [17:0] BACKDOOR_KEY_BASE = 18'h3ff00;
  localparam logic [17:0] BACKDOOR_KEY_END = 18'h3ff07;
  localparam logic [17:0] CFG_RESERVED_BASE = 18'h3ff08;
  localparam logic [17:0] CFG_PROG_GUARD = 18'h3ff0c;
  localparam logic [17:0] CFG_DATA_GUARD = 18'h3ff0d;
  localparam logic [17:0] CFG_OPTION = 18'h3ff0e;
  localparam logic [17:0] CFG_LOCKDOWN = 18'h3ff0f;
  localparam logic [17:0] VERSION_ID_BASE = 18'h040b6;
  localparam logic [17:0] VERSION_ID_END = 18'h040b7;
  localparam logic [17:0] PROGRAM_ONCE_BASE = 18'h040c0;
  localparam logic [17:0] PROGRAM_ONCE_END = 18'h040ff;
  localparam logic [17:0] PROG_IFR_END = 18'h040ff;

  // ****************************************************************
  // Decode regions
  // ****************************************************************
  typedef enum logic [5:0] {
    RGN_NONE = 6'h01,
    RGN_REGS = 6'h02,
    RGN_DATA = 6'h04,
    RGN_IFR = 6'h08,
    RGN_PROG = 6'h10,
    RGN_RSVD = 6'h20
  } region_e;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int MCLK_HZ = 20000000;
  localparam int TIMEBASE_HZ = 1000000;

endpackage
